// >>> include/occ_pkg.sv
package occ_pkg;

	// Register offsets on the plain register port.
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_OSC_CONTROL = 4'h0;
	localparam logic [3:0] OFF_CLK_CONFIG = 4'h2;
	localparam logic [3:0] OFF_CLK_STATUS = 4'h4;

	// Oscillator control register fields.
	localparam int TRIM_HI_MSB = 15;
	localparam int TRIM_HI_LSB = 14;
	localparam int SEL_MSB = 13;
	localparam int SEL_LSB = 12;
	localparam int TRIM_LO_MSB = 11;
	localparam int TRIM_LO_LSB = 10;
	localparam int LOCK_BIT = 5;
	localparam int KEEP_ON_BIT = 1;

	// Clock configuration register fields.
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 0;
	localparam int MULT_MSB = 5;
	localparam int MULT_LSB = 4;
	localparam int PLL_EN_BIT = 8;
	localparam int WDT_EN_BIT = 9;
	localparam int CFM_EN_BIT = 10;

	// Clock status register fields.
	localparam int ST_SLOW_ON_BIT = 0;
	localparam int ST_POWERUP_DONE_BIT = 1;
	localparam int ST_PLL_USE_BIT = 2;
	localparam int ST_LP_ON_BIT = 3;
	localparam int ST_SRC_MSB = 6;
	localparam int ST_SRC_LSB = 4;
	localparam int ST_TRIM_MSB = 15;
	localparam int ST_TRIM_LSB = 8;

	// Reset values.
	localparam logic [1:0] SEL_RST = 2'h1;
	localparam logic [3:0] TRIM_RST = 4'h0;
	localparam logic KEEP_ON_RST = 1'b0;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [1:0] MULT_RST = 2'h0;

	// Current oscillator select codes.
	localparam logic [1:0] SEL_LP = 2'h0;
	localparam logic [1:0] SEL_FRC = 2'h1;
	localparam logic [1:0] SEL_SLOW = 2'h2;
	localparam logic [1:0] SEL_PRIMARY = 2'h3;

	// Multiplier gain codes; the fourth code is not a gain.
	localparam logic [1:0] MULT_X4 = 2'h0;
	localparam logic [1:0] MULT_X8 = 2'h1;
	localparam logic [1:0] MULT_X16 = 2'h2;

	// Output pin functions.
	localparam logic [1:0] PIN_CRYSTAL = 2'h0;
	localparam logic [1:0] PIN_CLKOUT = 2'h1;
	localparam logic [1:0] PIN_GPIO = 2'h2;
	localparam logic [3:0] MODE_EXT_LIMIT = 4'h4;

	// Timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOCK_SETTLE_NS = 10000;
	localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CNT_W = 8;

	localparam logic signed [7:0] TRIM_STEP_TENTHS = 8'sh0f;

	typedef enum logic [2:0] {
		OCC_SRC_LP,
		OCC_SRC_FRC,
		OCC_SRC_SLOW,
		OCC_SRC_PRIMARY,
		OCC_SRC_PRIMARY_PLL
	} occ_src_t;

	typedef enum logic [1:0] {
		OCC_LK_IDLE,
		OCC_LK_SETTLE,
		OCC_LK_TRACK
	} occ_lock_state_t;

	// Trim code as signed steps, result in tenths of a percent.
	function automatic logic signed [7:0] occ_trim_tenths(input logic [3:0] t);
		logic signed [7:0] steps;
		steps = signed'({{4{t[3]}}, t});
		return 8'(steps * TRIM_STEP_TENTHS);
	endfunction

	// Output pin use from the primary oscillator mode.
	function automatic logic [1:0] occ_pin_fn(input logic [3:0] mode);
		logic [1:0] fn;
		fn = PIN_CRYSTAL;
		if (mode < MODE_EXT_LIMIT) begin
			fn = mode[0] ? PIN_GPIO : PIN_CLKOUT;
		end
		return fn;
	endfunction

endpackage

// >>> include/occ_osc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface occ_osc_if;
	import occ_pkg::*;
	logic pll_in_use;
	logic reconfig;
	logic lock_sync;
	logic locked;
	logic wdt_en;
	logic cfm_en;
	logic [1:0] osc_sel;
	logic powerup_done;
	logic slow_on;

	modport ctrl (
		output pll_in_use, reconfig, lock_sync, wdt_en, cfm_en, osc_sel, powerup_done,
		input locked, slow_on
	);
	modport lock (
		input pll_in_use, reconfig, lock_sync,
		output locked
	);
	modport slow (
		input wdt_en, cfm_en, osc_sel, powerup_done,
		output slow_on
	);
endinterface
`default_nettype wire

// >>> core/occ_lock_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module occ_lock_monitor (
	input wire logic clk,
	input wire logic reset,
	occ_osc_if.lock osc
);
	import occ_pkg::*;

	occ_lock_state_t state;
	logic [LOCK_CNT_W-1:0] settle_cnt;

	// A fresh start ignores the loop's lock line for a settle time, since it may
	// still show the old lock before the loop has really slipped.
	always_ff @(posedge clk) begin
		if (reset || !osc.pll_in_use) begin
			state <= OCC_LK_IDLE;
			settle_cnt <= '0;
		end else if (osc.reconfig) begin
			state <= OCC_LK_SETTLE;
			settle_cnt <= '0;
		end else begin
			case (state)
				OCC_LK_IDLE: begin
					state <= OCC_LK_SETTLE;
					settle_cnt <= '0;
				end
				OCC_LK_SETTLE: begin
					settle_cnt <= settle_cnt + 1'b1;
					if (settle_cnt == LOCK_CNT_W'(LOCK_SETTLE_CYC - 1)) begin
						state <= OCC_LK_TRACK;
					end
				end
				default: begin
					state <= OCC_LK_TRACK;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			osc.locked <= 1'b0;
		end else begin
			osc.locked <= (state == OCC_LK_TRACK) && osc.pll_in_use && !osc.reconfig
				&& osc.lock_sync;
		end
	end
endmodule
`default_nettype wire

// >>> core/occ_slow_rc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module occ_slow_rc_ctrl (
	input wire logic clk,
	input wire logic reset,
	occ_osc_if.slow osc
);
	import occ_pkg::*;

	logic keep;

	assign keep = osc.cfm_en || osc.wdt_en || (osc.osc_sel == SEL_SLOW);

	// The power-up timer itself runs on this oscillator, so it must be on from reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			osc.slow_on <= 1'b1;
		end else if (!osc.powerup_done) begin
			osc.slow_on <= 1'b1;
		end else begin
			osc.slow_on <= keep;
		end
	end
endmodule
`default_nettype wire

// >>> core/occ_clock_control.sv
// What this block does
// - Multiplier gain is four, eight or sixteen.
// - Lock flag follows loop lock, drops on loss.
// - Lock flag is read-only in control register.
// - Select code 01 runs from fast RC.
// - Trim built from bits 15:14 and 11:10.
// - Trim is signed, 1.5 percent per step.
// - Slow RC clocks power-up, watchdog, clock monitor.
// - Slow RC always on at power-on reset.
// - After power-up delay, slow RC kept if needed.
// - Otherwise slow RC turns off after delay.
// - Output pin function set by primary mode field.
// - Input oscillator pin never offered as GPIO.
// - Low-power crystal clocks system only with keep-on.
// - Keep-on holds low-power crystal running, even asleep.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module occ_clock_control (
	input wire logic clk,
	input wire logic reset,
	input wire logic [occ_pkg::ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic pll_lock_pin,
	input wire logic powerup_expired_pin,
	output logic pll_enable,
	output logic [1:0] pll_mult_sel,
	output logic frc_enable,
	output logic [3:0] frc_trim,
	output logic signed [7:0] frc_trim_tenths,
	output logic slow_rc_enable,
	output logic lp_osc_enable,
	output occ_pkg::occ_src_t sys_clk_src,
	output logic [1:0] osc_output_fn,
	output logic osc_input_gpio_en,
	output logic pll_locked_flag
);
	import occ_pkg::*;

	occ_osc_if osc ();

	// Software-held state.
	logic [1:0] osc_sel;
	logic [3:0] trim;
	logic keep_on;
	logic [3:0] mode;
	logic [1:0] mult;
	logic pll_en;
	logic wdt_en;
	logic cfm_en;

	// Synchronisers for the analog lock line and the power-up timer expiry.
	logic lock_meta;
	logic lock_sync;
	logic powerup_meta;
	logic powerup_sync;

	logic pll_in_use;
	logic reconfig;

	logic wr_ctl;
	logic wr_cfg;
	logic [1:0] next_mult;
	logic next_pll_in_use;
	logic [15:0] ctl_word;
	logic [15:0] cfg_word;
	logic [15:0] status_word;
	occ_src_t next_src;

	assign wr_ctl = wr && (addr == OFF_OSC_CONTROL);
	assign wr_cfg = wr && (addr == OFF_CLK_CONFIG);

	always_ff @(posedge clk) begin
		if (reset) begin
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
			powerup_meta <= 1'b0;
			powerup_sync <= 1'b0;
		end else begin
			lock_meta <= pll_lock_pin;
			lock_sync <= lock_meta;
			powerup_meta <= powerup_expired_pin;
			powerup_sync <= powerup_meta;
		end
	end

	// Oscillator control register; bit LOCK_BIT is not stored, so writes to it vanish.
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_sel <= SEL_RST;
			trim <= TRIM_RST;
			keep_on <= KEEP_ON_RST;
		end else if (wr_ctl) begin
			osc_sel <= wdata[SEL_MSB:SEL_LSB];
			trim <= {wdata[TRIM_HI_MSB:TRIM_HI_LSB], wdata[TRIM_LO_MSB:TRIM_LO_LSB]};
			keep_on <= wdata[KEEP_ON_BIT];
		end
	end

	// A write of the unused gain code keeps the previous gain.
	always_comb begin
		next_mult = mult;
		if (wdata[MULT_MSB:MULT_LSB] == MULT_X4 || wdata[MULT_MSB:MULT_LSB] == MULT_X8
			|| wdata[MULT_MSB:MULT_LSB] == MULT_X16) begin
			next_mult = wdata[MULT_MSB:MULT_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode <= MODE_RST;
			mult <= MULT_RST;
			pll_en <= 1'b0;
			wdt_en <= 1'b0;
			cfm_en <= 1'b0;
		end else if (wr_cfg) begin
			mode <= wdata[MODE_MSB:MODE_LSB];
			mult <= next_mult;
			pll_en <= wdata[PLL_EN_BIT];
			wdt_en <= wdata[WDT_EN_BIT];
			cfm_en <= wdata[CFM_EN_BIT];
		end
	end

	// The loop is in use only while it drives the system clock.
	always_comb begin
		next_pll_in_use = pll_en && (osc_sel == SEL_PRIMARY);
		if (wr_ctl) begin
			next_pll_in_use = pll_en && (wdata[SEL_MSB:SEL_LSB] == SEL_PRIMARY);
		end
		if (wr_cfg) begin
			next_pll_in_use = wdata[PLL_EN_BIT] && (osc_sel == SEL_PRIMARY);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pll_in_use <= 1'b0;
			reconfig <= 1'b0;
		end else begin
			pll_in_use <= next_pll_in_use;
			reconfig <= next_pll_in_use && (!pll_in_use || (wr_cfg && next_mult != mult));
		end
	end

	assign osc.pll_in_use = pll_in_use;
	assign osc.reconfig = reconfig;
	assign osc.lock_sync = lock_sync;
	assign osc.wdt_en = wdt_en;
	assign osc.cfm_en = cfm_en;
	assign osc.osc_sel = osc_sel;
	assign osc.powerup_done = powerup_sync;

	occ_lock_monitor u_lock (
		.clk(clk),
		.reset(reset),
		.osc(osc.lock)
	);

	// Slow RC also serves the watchdog and clock monitor through slow_rc_enable.
	occ_slow_rc_ctrl u_slow (
		.clk(clk),
		.reset(reset),
		.osc(osc.slow)
	);

	assign pll_locked_flag = osc.locked;
	assign slow_rc_enable = osc.slow_on;

	// Without the keep-on bit the low-power crystal is not running, so fall back to fast RC.
	always_comb begin
		next_src = OCC_SRC_FRC;
		case (osc_sel)
			SEL_LP: begin
				next_src = keep_on ? OCC_SRC_LP : OCC_SRC_FRC;
			end
			SEL_FRC: begin
				next_src = OCC_SRC_FRC;
			end
			SEL_SLOW: begin
				next_src = OCC_SRC_SLOW;
			end
			default: begin
				next_src = pll_en ? OCC_SRC_PRIMARY_PLL : OCC_SRC_PRIMARY;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sys_clk_src <= OCC_SRC_FRC;
			frc_enable <= 1'b1;
			frc_trim <= TRIM_RST;
			frc_trim_tenths <= occ_trim_tenths(TRIM_RST);
			pll_enable <= 1'b0;
			pll_mult_sel <= MULT_RST;
			lp_osc_enable <= KEEP_ON_RST;
		end else begin
			sys_clk_src <= next_src;
			frc_enable <= (next_src == OCC_SRC_FRC);
			frc_trim <= trim;
			frc_trim_tenths <= occ_trim_tenths(trim);
			pll_enable <= pll_in_use;
			pll_mult_sel <= mult;
			lp_osc_enable <= keep_on || (next_src == OCC_SRC_LP);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			osc_output_fn <= occ_pin_fn(MODE_RST);
			osc_input_gpio_en <= 1'b0;
		end else begin
			osc_output_fn <= occ_pin_fn(mode);
			osc_input_gpio_en <= 1'b0;
		end
	end

	always_comb begin
		ctl_word = '0;
		ctl_word[TRIM_HI_MSB:TRIM_HI_LSB] = trim[3:2];
		ctl_word[SEL_MSB:SEL_LSB] = osc_sel;
		ctl_word[TRIM_LO_MSB:TRIM_LO_LSB] = trim[1:0];
		ctl_word[LOCK_BIT] = osc.locked;
		ctl_word[KEEP_ON_BIT] = keep_on;
	end

	always_comb begin
		cfg_word = '0;
		cfg_word[MODE_MSB:MODE_LSB] = mode;
		cfg_word[MULT_MSB:MULT_LSB] = mult;
		cfg_word[PLL_EN_BIT] = pll_en;
		cfg_word[WDT_EN_BIT] = wdt_en;
		cfg_word[CFM_EN_BIT] = cfm_en;
	end

	always_comb begin
		status_word = '0;
		status_word[ST_SLOW_ON_BIT] = osc.slow_on;
		status_word[ST_POWERUP_DONE_BIT] = powerup_sync;
		status_word[ST_PLL_USE_BIT] = pll_in_use;
		status_word[ST_LP_ON_BIT] = lp_osc_enable;
		status_word[ST_SRC_MSB:ST_SRC_LSB] = sys_clk_src;
		status_word[ST_TRIM_MSB:ST_TRIM_LSB] = frc_trim_tenths;
	end

	// Read data stands for one cycle only; unmapped offsets read as zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= '0;
		end else if (rd) begin
			if (addr == OFF_OSC_CONTROL) begin
				rdata <= ctl_word;
			end else if (addr == OFF_CLK_CONFIG) begin
				rdata <= cfg_word;
			end else if (addr == OFF_CLK_STATUS) begin
				rdata <= status_word;
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// >>> dv/occ_clock_control_chk.sv
`timescale 1ns/100ps
`default_nettype none
module occ_clock_control_chk
	import occ_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [occ_pkg::ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic pll_lock_pin,
	input wire logic powerup_expired_pin,
	input wire logic pll_enable,
	input wire logic [1:0] pll_mult_sel,
	input wire logic frc_enable,
	input wire logic [3:0] frc_trim,
	input wire logic signed [7:0] frc_trim_tenths,
	input wire logic slow_rc_enable,
	input wire logic lp_osc_enable,
	input wire occ_pkg::occ_src_t sys_clk_src,
	input wire logic [1:0] osc_output_fn,
	input wire logic osc_input_gpio_en,
	input wire logic pll_locked_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_unused;
		!pll_enable [*3];
	endsequence
	property p_gpio;
		osc_input_gpio_en == 1'b0;
	endproperty
	a_gpio: assert property (p_gpio) else $error("input pin offered as gpio");
	property p_mult;
		pll_mult_sel != 2'h3;
	endproperty
	a_mult: assert property (p_mult) else $error("illegal gain");
	property p_frc;
		$stable(sys_clk_src) |-> frc_enable == (sys_clk_src == OCC_SRC_FRC);
	endproperty
	a_frc: assert property (p_frc) else $error("fast rc enable wrong");
	property p_tenths;
		frc_trim == $past(frc_trim) |->
			frc_trim_tenths == 8'($signed({{4{frc_trim[3]}}, frc_trim}) * 8'sd15);
	endproperty
	a_tenths: assert property (p_tenths) else $error("trim step wrong");
	property p_unused;
		s_unused |-> !pll_locked_flag;
	endproperty
	a_unused: assert property (p_unused) else $error("lock while unused");
	property p_settle;
		$rose(pll_enable) |-> !pll_locked_flag [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("lock too early");
	property p_rose;
		$rose(pll_locked_flag) |-> pll_enable;
	endproperty
	a_rose: assert property (p_rose) else $error("lock without loop");
	property p_rdata;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data not idle");
	property p_slow_rst;
		disable iff (1'b0) reset |=> slow_rc_enable;
	endproperty
	a_slow_rst: assert property (p_slow_rst) else $error("slow rc off in reset");
	property p_slow_sel;
		(sys_clk_src == OCC_SRC_SLOW) [*3] |-> slow_rc_enable;
	endproperty
	a_slow_sel: assert property (p_slow_sel) else $error("slow rc off as source");
	property p_lp;
		$stable(sys_clk_src) && sys_clk_src == OCC_SRC_LP |-> lp_osc_enable;
	endproperty
	a_lp: assert property (p_lp) else $error("crystal off as source");
endmodule
bind occ_clock_control occ_clock_control_chk u_chk (.clk, .reset, .addr, .wdata, .wr, .rd,
	.rdata, .pll_lock_pin, .powerup_expired_pin, .pll_enable, .pll_mult_sel, .frc_enable,
	.frc_trim, .frc_trim_tenths, .slow_rc_enable, .lp_osc_enable, .sys_clk_src,
	.osc_output_fn, .osc_input_gpio_en, .pll_locked_flag);
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import occ_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pll_lock_pin = 1'b0;
	logic powerup_expired_pin = 1'b0;
	logic [15:0] rdata;
	logic pll_enable, frc_enable, slow_rc_enable, lp_osc_enable, osc_input_gpio_en;
	logic pll_locked_flag;
	logic [1:0] pll_mult_sel, osc_output_fn;
	logic [3:0] frc_trim, tv;
	logic signed [7:0] frc_trim_tenths;
	occ_src_t sys_clk_src;
	int errors = 0;
	int total_checks = 0;
	int n;
	logic [15:0] sw [5] = '{16'h0000, 16'h0002, 16'h1002, 16'h2000, 16'h3000};
	logic [2:0] se [5] = '{3'h1, 3'h0, 3'h1, 3'h2, 3'h3};
	logic [15:0] rc [4] = '{16'h3000, 16'h3000, 16'h2000, 16'h3000};
	logic [15:0] rg [4] = '{16'h0200, 16'h0400, 16'h0000, 16'h0000};

	always #25 clk = ~clk;

	occ_clock_control uut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .pll_lock_pin,
		.powerup_expired_pin, .pll_enable, .pll_mult_sel, .frc_enable, .frc_trim,
		.frc_trim_tenths, .slow_rc_enable, .lp_osc_enable, .sys_clk_src, .osc_output_fn,
		.osc_input_gpio_en, .pll_locked_flag);

	task automatic results();
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// A hung design still ends with a verdict.
	initial begin
		#5000000;
		errors++;
		results();
	end

	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		wt(3);
		chk("slow_on", 16'h1, {15'h0, slow_rc_enable});
		chk("in_gpio", 16'h0, {15'h0, osc_input_gpio_en});
		chk("out_fn", {14'h0, PIN_CLKOUT}, {14'h0, osc_output_fn});
		rchk("control", OFF_OSC_CONTROL, 16'h1000);
		rchk("status", OFF_CLK_STATUS, 16'h0011);
		rchk("unmapped", 4'h6, 16'h0000);
		wreg(4'h6, 16'hffff);
		wreg(OFF_CLK_STATUS, 16'hffff);
		rchk("status", OFF_CLK_STATUS, 16'h0011);
		for (int t = 0; t < 16; t++) begin
			tv = 4'(t);
			n = (t > 7) ? t - 16 : t;
			wreg(OFF_OSC_CONTROL, {tv[3:2], 2'b01, tv[1:0], 10'h020});
			wt(3);
			chk("trim", {12'h0, tv}, {12'h0, frc_trim});
			chk("tenths", {8'h0, 8'(n * 15)}, {8'h0, frc_trim_tenths});
			chk("frc_on", 16'h1, {15'h0, frc_enable});
			rchk("control", OFF_OSC_CONTROL, {tv[3:2], 2'b01, tv[1:0], 10'h000});
		end
		for (int i = 0; i < 5; i++) begin
			wreg(OFF_OSC_CONTROL, sw[i]);
			wt(3);
			chk("src", {13'h0, se[i]}, {13'h0, sys_clk_src});
			chk("frc_on", {15'h0, se[i] == 3'h1}, {15'h0, frc_enable});
			chk("lp_on", {15'h0, sw[i][1] | (se[i] == 3'h0)}, {15'h0, lp_osc_enable});
		end
		@(posedge clk);
		pll_lock_pin <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wreg(OFF_CLK_CONFIG, 16'h0100 | 16'(m << 4));
			wt(3);
			chk("mult", {14'h0, (m == 3) ? 2'h2 : 2'(m)}, {14'h0, pll_mult_sel});
		end
		rchk("config", OFF_CLK_CONFIG, 16'h0120);
		wreg(OFF_CLK_CONFIG, 16'h0000);
		wt(3);
		chk("lock_off", 16'h0, {15'h0, pll_locked_flag});
		wreg(OFF_CLK_CONFIG, 16'h0120);
		n = 0;
		while (pll_locked_flag !== 1'b1 && n < 400) begin
			wt(1);
			n++;
		end
		chk("lock_wait", 16'h1, {15'h0, n >= LOCK_SETTLE_CYC && n <= LOCK_SETTLE_CYC + 4});
		if (n >= 400) begin
			results();
		end
		rchk("control", OFF_OSC_CONTROL, 16'h3020);
		@(posedge clk);
		pll_lock_pin <= 1'b0;
		wt(6);
		chk("lock_lost", 16'h0, {15'h0, pll_locked_flag});
		@(posedge clk);
		pll_lock_pin <= 1'b1;
		wt(6);
		chk("relock", 16'h1, {15'h0, pll_locked_flag});
		chk("pll_on", 16'h1, {15'h0, pll_enable});
		wreg(OFF_CLK_CONFIG, 16'h0110);
		wt(3);
		chk("lock_reconf", 16'h0, {15'h0, pll_locked_flag});
		wreg(OFF_CLK_CONFIG, 16'h0000);
		wt(3);
		chk("pll_off", 16'h0, {15'h0, pll_enable});
		for (int m = 0; m < 16; m++) begin
			tv = 4'(m);
			wreg(OFF_CLK_CONFIG, {12'h0, tv});
			wt(3);
			chk("out_fn", {14'h0, (m < 4) ? (tv[0] ? PIN_GPIO : PIN_CLKOUT) : PIN_CRYSTAL},
				{14'h0, osc_output_fn});
		end
		@(posedge clk);
		powerup_expired_pin <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wreg(OFF_OSC_CONTROL, rc[i]);
			wreg(OFF_CLK_CONFIG, rg[i]);
			wt(6);
			chk("slow_on", {15'h0, i < 3}, {15'h0, slow_rc_enable});
		end
		// A second reset must bring the slow oscillator back although nothing keeps it.
		@(posedge clk);
		reset <= 1'b1;
		wt(2);
		chk("slow_rst", 16'h1, {15'h0, slow_rc_enable});
		@(posedge clk);
		reset <= 1'b0;
		wt(3);
		rchk("control", OFF_OSC_CONTROL, 16'h1000);
		results();
	end
endmodule
`default_nettype wire
